/* File: src/xpt_ctrl_regs.vh */
// Purpose: Constants for the crosspoint serial configuration controller
// Assumes: 16 inputs, 8 outputs, 5-bit output groups in the frame
// Notes: Frame bit 0 is the first bit shifted in
// Notes on behaviour
// R01: Addressed word: output, input, off bit
// R02: Earliest shifted bit is bit zero
// R03: Cascade output only in frame format
// R04: Host feeds first device, chains onward
// R05: Serial output shows previously held bits
// R06: Host gives 80 clocks then deselects
// R07: One configure pulse activates all devices
// R08: Shared control lines behave identically
// R09: Reset and broadcast ignore serial bus
// R10: Reset: input zero, all outputs off
// R11: Broadcast: all outputs on, input zero
// R12: Ignore bus when select high; falling edge
// R13: Matrix updates only on configure pulse
// R14: Mode high addressed, low frame format
// R15: Frame: 8 groups, 4-bit input, off
// R16: Reset wins over broadcast
`ifndef XPT_CTRL_REGS_VH
`define XPT_CTRL_REGS_VH
`define FRAME_BITS      40
`define ADDR_WORD_BITS  8
`define GROUP_BITS      5
`define AW_OUT_LSB      0
`define AW_IN_LSB       3
`define AW_OFF_BIT      7
`define GRP_OFF_BIT     4
`define RST_INPUT_SEL   4'h0
`define RST_OFF         1'b1
`define BROADCAST_INPUT_SEL 4'h0
`endif

/* File: src/sync2.v */
// Purpose: Two-flop synchroniser for one level
// Assumes: Asynchronous input, one destination clock
// Notes: First flop feeds only the second
`timescale 1ns/1ns
`default_nettype none
module sync2
(
	input  wire core_clk,
	input  wire rst,
	input  wire d,
	output reg  q
);
	reg meta_reg;
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end
		else
		begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* File: src/xpt_ctrl.v */
// Purpose: Serial load register and active matrix for a 16x8 crosspoint
// Assumes: Serial clock sampled by core_clk, far slower than core_clk
// Notes: Pins enter through two-flop synchronisers
`timescale 1ns/1ns
`default_nettype none
`include "xpt_ctrl_regs.vh"
module xpt_ctrl
#(
	parameter N_OUT = 8,
	parameter IN_W  = 4
)
(
	input  wire                core_clk,
	input  wire                rst,
	input  wire                ser_clk,
	input  wire                ser_din,
	input  wire                cs_n,
	input  wire                mode_addr,
	input  wire                cfg,
	input  wire                xpt_reset,
	input  wire                broadcast_input_zero,
	output reg                 ser_dout,
	output reg  [N_OUT*IN_W-1:0] out_sel,
	output reg  [N_OUT-1:0]    out_off
);
	localparam FB = `FRAME_BITS;

	wire clk_s;
	wire din_s;
	wire cs_n_s;
	wire mode_s;
	wire cfg_s;
	wire xrst_s;
	wire bzero_s;

	// R08 shared pins
	// Every pin has its own synchroniser, so common sources behave alike
	sync2 u_clk
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        (ser_clk),
		.q        (clk_s)
	);
	sync2 u_din
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        (ser_din),
		.q        (din_s)
	);
	sync2 u_cs
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        (cs_n),
		.q        (cs_n_s)
	);
	sync2 u_mode
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        (mode_addr),
		.q        (mode_s)
	);
	sync2 u_cfg
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        (cfg),
		.q        (cfg_s)
	);
	sync2 u_xrst
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        (xpt_reset),
		.q        (xrst_s)
	);
	sync2 u_bzero
	(
		.core_clk (core_clk),
		.rst      (rst),
		.d        (broadcast_input_zero),
		.q        (bzero_s)
	);

	////////////////////////////////////////////////////////////////
	reg          clk_d_reg;
	reg          cfg_d_reg;
	reg [FB-1:0] load_reg;
	reg          fresh_reg;
	reg [N_OUT*IN_W-1:0] act_sel_reg;
	reg [N_OUT-1:0]      act_off_reg;
	wire fall = clk_d_reg & ~clk_s;
	// R07 configure edge
	// One edge per pulse, so a shared pulse acts on all parts together
	wire cfg_rise = cfg_s & ~cfg_d_reg;
	// R12 falling edge gated
	wire shift_en = fall & ~cs_n_s;

	// R02 first bit lands low
	// Shift toward bit 0; first bit ends at 0 after a full frame
	wire [FB-1:0] frame_next = {din_s, load_reg[FB-1:1]};
	wire [`ADDR_WORD_BITS-1:0] aw = load_reg[FB-1:FB-`ADDR_WORD_BITS];
	wire [2:0]      aw_out = aw[`AW_OUT_LSB+2:`AW_OUT_LSB];
	wire [IN_W-1:0] aw_in  = aw[`AW_IN_LSB+IN_W-1:`AW_IN_LSB];
	wire            aw_off = aw[`AW_OFF_BIT];

	////////////////////////////////////////////////////////////////
	// Previous levels for the edge detectors
	// Reset level matches the idle pins, so no false edge after reset
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			clk_d_reg <= 1'b0;
			cfg_d_reg <= 1'b0;
		end
		else
		begin
			clk_d_reg <= clk_s;
			cfg_d_reg <= cfg_s;
		end
	end

	////////////////////////////////////////////////////////////////
	// R05 R03 chain output
	// Mirrors the bit that the next fall moves out, so a part
	// chained behind samples each bit on that same fall
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ser_dout <= 1'b0;
		end
		// Addressed words never cascade
		else if (mode_s)
		begin
			ser_dout <= 1'b0;
		end
		else if (shift_en)
		begin
			ser_dout <= frame_next[0];
		end
		else
		begin
			ser_dout <= load_reg[0];
		end
	end

	////////////////////////////////////////////////////////////////
	integer i;
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			load_reg    <= {FB{1'b0}};
			fresh_reg   <= 1'b0;
			act_sel_reg <= {N_OUT*IN_W{1'b0}};
			act_off_reg <= {N_OUT{`RST_OFF}};
		end
		else
		begin
			if (shift_en)
			begin
				load_reg  <= frame_next;
				fresh_reg <= 1'b1;
			end
			// R10 R16 reset first
			// Reset overrides the configure copy but not the shift, independent of the serial bus
			if (xrst_s)
			begin
				act_sel_reg <= {N_OUT{`RST_INPUT_SEL}};
				act_off_reg <= {N_OUT{`RST_OFF}};
			end
			// R13 configure copies
			// A fresh shift beside the pulse is still kept for the next one
			else if (cfg_rise && fresh_reg)
			begin
				fresh_reg <= shift_en;
				// R14 format select
				if (mode_s)
				begin
					// R01 addressed word
					act_sel_reg[aw_out*IN_W +: IN_W] <= aw_in;
					act_off_reg[aw_out]              <= aw_off;
				end
				else
				begin
					// R15 whole frame
					for (i = 0; i < N_OUT; i = i + 1)
					begin
						act_sel_reg[i*IN_W +: IN_W] <= load_reg[i*`GROUP_BITS +: IN_W];
						act_off_reg[i]              <= load_reg[i*`GROUP_BITS+`GRP_OFF_BIT];
					end
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// R09 R11 broadcast overlay
	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			out_sel <= {N_OUT*IN_W{1'b0}};
			out_off <= {N_OUT{1'b1}};
		end
		else if (xrst_s)
		begin
			out_sel <= {N_OUT{`RST_INPUT_SEL}};
			out_off <= {N_OUT{`RST_OFF}};
		end
		else if (bzero_s)
		begin
			out_sel <= {N_OUT{`BROADCAST_INPUT_SEL}};
			out_off <= {N_OUT{1'b0}};
		end
		else
		begin
			out_sel <= act_sel_reg;
			out_off <= act_off_reg;
		end
	end
endmodule
`default_nettype wire

/* File: verification/xpt_ctrl_checker.sv */
// Purpose: port checks. Assumes: pins act 3 cycles on. Notes: windows padded
`timescale 1ns/1ns
`default_nettype none
module xpt_ctrl_checker(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic mode_addr,
	input wire logic cfg,
	input wire logic xpt_reset,
	input wire logic broadcast_input_zero,
	input wire logic ser_dout,
	input wire logic [31:0] out_sel,
	input wire logic [7:0] out_off
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_rst; xpt_reset[*5] |-> &out_off && !out_sel; endproperty
	a_rst: assert property (p_rst) else $error("reset");
	property p_bc; (broadcast_input_zero && !xpt_reset)[*5] |-> !out_off && !out_sel; endproperty
	a_bc: assert property (p_bc) else $error("broadcast");
	property p_both; (xpt_reset && broadcast_input_zero)[*3] |-> ##2 &out_off; endproperty
	a_both: assert property (p_both) else $error("priority");
	property p_rise; $rose(xpt_reset) |-> ##[1:4] &out_off; endproperty
	a_rise: assert property (p_rise) else $error("reset");
	property p_fall; $fell(xpt_reset) && broadcast_input_zero |-> ##[1:4] !out_off; endproperty
	a_fall: assert property (p_fall) else $error("on");
	property p_hold; (!cfg && !xpt_reset && !broadcast_input_zero)[*6] |-> $stable(out_sel) && $stable(out_off); endproperty
	a_hold: assert property (p_hold) else $error("hold");
	property p_adr; mode_addr[*6] |-> !ser_dout; endproperty
	a_adr: assert property (p_adr) else $error("chain");
	property p_cs; (cs_n && !mode_addr)[*5] |-> $stable(ser_dout); endproperty
	a_cs: assert property (p_cs) else $error("select");
	c_cfg: cover property ($rose(cfg));
	c_adr: cover property (mode_addr && !cs_n);
	c_both: cover property (xpt_reset && broadcast_input_zero);
endmodule
`default_nettype wire

/* File: verification/host_model.sv */
// Purpose: serial host. Assumes: 80 ns half period. Notes: released data inverts
`timescale 1ns/1ns
`default_nettype none
module host_model(
	input wire logic core_clk,
	input wire logic ser_dout,
	output var logic ser_clk,
	output var logic ser_din,
	output var logic cs_n
);
	logic [80:0] got;
	initial {ser_clk, ser_din, cs_n} = 3'b001;
	task automatic tk(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// lsb first
	// Dout is taken just before each fall, as a chained part would
	task automatic send(input logic [79:0] v, input int n);
		for (int i = 0; i <= n; i++)
		begin
			{cs_n, ser_din} <= {i == n, i < n ? v[i] : !ser_din};
			tk(4);
			ser_clk <= 1'b1;
			tk(8);
			got[i] = ser_dout;
			ser_clk <= 1'b0;
			tk(4);
		end
	endtask
endmodule
`default_nettype wire

/* File: verification/test_crosspoint_serial_config_ctrl.sv */
// Purpose: bench. Assumes: host model on the bus. Notes: pins settle in 3 cycles, checked after 5
`timescale 1ns/1ns
`default_nettype none
module test_crosspoint_serial_config_ctrl;
	logic core_clk = 1'b0, rst = 1'b1, cfg = 1'b0, mode_addr = 1'b0, xpt_reset = 1'b0;
	logic broadcast_input_zero = 1'b0, ser_clk, ser_din, cs_n, ser_dout;
	logic [31:0] out_sel;
	logic [7:0] out_off;
	logic [39:0] e = {8'hff, 32'h0}, g = 40'h5ac3e1782d;
	int err_total = 0, num_checks = 0;
	always #5 core_clk = ~core_clk;
	xpt_ctrl dut (.core_clk(core_clk), .rst(rst), .ser_clk(ser_clk), .ser_din(ser_din), .cs_n(cs_n),
		.mode_addr(mode_addr), .cfg(cfg), .xpt_reset(xpt_reset),
		.broadcast_input_zero(broadcast_input_zero), .ser_dout(ser_dout), .out_sel(out_sel),
		.out_off(out_off));
	host_model h (.core_clk(core_clk), .ser_dout(ser_dout), .ser_clk(ser_clk), .ser_din(ser_din),
		.cs_n(cs_n));
	task automatic chk(input logic [39:0] a, b);
		num_checks++;
		err_total += int'(a !== b);
		if (a !== b)
			$display("BAD %0t %h %h", $time, a, b);
	endtask
	task automatic pulse;
		cfg <= 1'b1;
		h.tk(2);
		cfg <= 1'b0;
		h.tk(6);
	endtask
	task automatic t_load;
		chk({out_off, out_sel}, e);
		h.send({g, 40'h3ca5960f71}, 80);
		chk(h.got[79:40], 40'h3ca5960f71);
		for (int k = 0; k < 8; k++)
			{e[32+k], e[4*k+:4]} = g[5*k+:5];
		pulse;
		chk({out_off, out_sel}, e);
		mode_addr <= 1'b1;
		h.send(80'h4b, 8);
		h.send(80'h95, 8);
		pulse;
		{e[37], e[23:20]} = 5'h12;
		chk({out_off, out_sel}, e);
	endtask
	task automatic t_pins;
		{xpt_reset, broadcast_input_zero} <= 2'b11;
		h.tk(5);
		chk({out_off, out_sel}, {8'hff, 32'h0});
		xpt_reset <= 1'b0;
		h.tk(5);
		chk({out_off, out_sel}, 40'h0);
		broadcast_input_zero <= 1'b0;
		h.tk(5);
		chk({out_off, out_sel}, {8'hff, 32'h0});
		pulse;
		chk({out_off, out_sel}, {8'hff, 32'h0});
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		h.tk(5);
		rst <= 1'b0;
		t_load;
		t_pins;
		summarize;
	end
endmodule
bind xpt_ctrl xpt_ctrl_checker chk_i (
	.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .mode_addr(mode_addr), .cfg(cfg),
	.xpt_reset(xpt_reset), .broadcast_input_zero(broadcast_input_zero),
	.ser_dout(ser_dout), .out_sel(out_sel), .out_off(out_off)
);
`default_nettype wire
